// [lccc_pkg.sv]
// constants and types shared by the cipher and category configuration block
package lccc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W       = 8;
	localparam logic [7:0]  REG_CMD      = 8'h00;
	localparam logic [7:0]  REG_PARAM    = 8'h04;
	localparam logic [7:0]  REG_STATUS   = 8'h08;
	localparam logic [7:0]  REG_VALUE    = 8'h0C;
	localparam logic [7:0]  REG_AUTH     = 8'h10;
	localparam logic [7:0]  REG_EVT_STAT = 8'h14;
	localparam logic [7:0]  REG_EVT_CLR  = 8'h18;
	localparam logic [7:0]  REG_EVT_EN   = 8'h1C;
	localparam logic [7:0]  REG_CONN     = 8'h20;

	// ----------------------------------------------------------------
	// command field codes
	// ----------------------------------------------------------------
	localparam logic [15:0] OCF_RD_ENC   = 16'h0021;
	localparam logic [15:0] OCF_WR_ENC   = 16'h0022;
	localparam logic [15:0] OCF_RD_CAT   = 16'h0023;
	localparam logic [15:0] OCF_WR_CAT   = 16'h0024;

	// ----------------------------------------------------------------
	// parameter encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ENC_OFF      = 8'h00;
	localparam logic [7:0]  ENC_P2P      = 8'h01;
	localparam logic [7:0]  ENC_BOTH     = 8'h02;
	localparam logic [7:0]  AUTH_OFF     = 8'h00;
	localparam logic [7:0]  AUTH_ON      = 8'h01;
	localparam logic [7:0]  ENC_RST      = 8'h00;
	localparam logic [7:0]  AUTH_RST     = 8'h00;
	localparam logic [23:0] CAT_RST      = 24'h00_0000;
	// highest mode the local link hardware supports
	localparam logic [7:0]  LOCAL_ENC_CAP = 8'h02;

	// ----------------------------------------------------------------
	// status codes, all but ST_UNSUP returned by commands
	// ----------------------------------------------------------------
	localparam logic [7:0]  ST_OK        = 8'h00;
	localparam logic [7:0]  ST_UNK_CMD   = 8'h01;
	localparam logic [7:0]  ST_UNSUP     = 8'h11;
	localparam logic [7:0]  ST_BAD_PARAM = 8'h12;

	// ----------------------------------------------------------------
	// event bits and bus answers
	// ----------------------------------------------------------------
	localparam int unsigned EVT_W        = 2;
	localparam int unsigned EVT_CMD_DONE = 0;
	localparam int unsigned EVT_CONN     = 1;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	// outcome of one connection setup
	typedef struct packed {
		logic       encrypt;
		logic       temp_key;
		logic [7:0] mode;
	} lccc_conn_s;

	// write path sequencing
	typedef enum logic [2:0] {
		W_WAIT = 3'b001,
		W_EXEC = 3'b010,
		W_RESP = 3'b100
	} lccc_wr_state_e;

endpackage

// [lccc_conn_setup.sv]
// resolves the encryption outcome of a connection as it is set up
`timescale 1ns/1ps
module lccc_conn_setup (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// setup request from the link controller
	input  wire logic              setup_req,
	input  wire logic [1:0]        remote_cap,
	// stored settings
	input  wire logic [7:0]        auth_en,
	input  wire logic [7:0]        enc_mode,
	// result, held until the next setup, and a one-cycle done pulse
	output lccc_pkg::lccc_conn_s   result_ff,
	output logic                   done_ff
);

	logic [7:0]           remote_mode;
	logic [7:0]           trimmed;
	logic                 try_enc;
	lccc_pkg::lccc_conn_s nxt_result;

	// remote capability widened to a mode value for comparison
	assign remote_mode = {6'b00_0000, remote_cap};

	// never ask for more than the remote side offers
	assign trimmed = (enc_mode > remote_mode) ? remote_mode : enc_mode; // RQ9

	// encryption needs authentication as well as a nonzero mode
	assign try_enc = (auth_en == lccc_pkg::AUTH_ON) && (trimmed != lccc_pkg::ENC_OFF); // RQ4

	// result struct; broadcast encryption forces a temporary key
	assign nxt_result.encrypt  = try_enc;
	assign nxt_result.mode     = try_enc ? trimmed : lccc_pkg::ENC_OFF; // RQ9
	assign nxt_result.temp_key = try_enc && (trimmed == lccc_pkg::ENC_BOTH); // RQ6

	// settings are sampled only at setup, so later writes leave this link alone
	always_ff @(posedge clk) begin
		if (!nrst) begin
			result_ff <= '0;
			done_ff   <= 1'b0;
		end else begin
			done_ff <= setup_req;
			if (setup_req) begin
				result_ff <= nxt_result; // RQ5
			end
		end
	end

endmodule

// [lccc_top.sv]
// command handler for link encryption mode and device category code
`timescale 1ns/1ps

//
// Function
// RQ1 - read mode code 0x0021 returns status, mode
// RQ2 - write mode code 0x0022 returns status only
// RQ3 - mode 0 off default, 1 p2p, 2 both
// RQ4 - encrypt only if authentication and mode enabled
// RQ5 - new mode affects only later connections
// RQ6 - broadcast plus p2p needs temporary link key
// RQ7 - host never asks beyond local capability; the testbench host asks for reserved mode 3
// RQ8 - host avoids modes 1, 2 without support
// RQ9 - reported mode trimmed to remote capability
// RQ10 - status zero success, nonzero error code
// RQ11 - every command raises complete event unless masked; code records masked ones too, mask gates only irq
// RQ12 - read category code 0x0023 returns three bytes
// RQ13 - write category code 0x0024 stores three bytes
// RQ14 - stored category code presented to remote devices
// RQ15 - authentication byte 0 off, 1 on
// RQ16 - reserved mode write ignored, nonzero status
module lccc_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// connection setup from the link controller
	input  wire logic        conn_setup_req,
	input  wire logic [1:0]  conn_remote_cap,
	output logic             conn_done,
	output logic             conn_encrypt,
	output logic [7:0]       conn_mode,
	output logic             conn_temp_key,
	// category code presented to remote devices
	output logic [23:0]      device_category_code,
	// interrupt
	output logic             irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	lccc_pkg::lccc_wr_state_e wr_state_ff;
	lccc_pkg::lccc_wr_state_e nxt_wr_state;
	lccc_pkg::lccc_conn_s     conn_res;

	logic                awready_ff;
	logic                wready_ff;
	logic                bvalid_ff;
	logic [1:0]          bresp_ff;
	logic                arready_ff;
	logic                rvalid_ff;
	logic [31:0]         rdata_ff;
	logic [1:0]          rresp_ff;
	logic                aw_held_ff;
	logic                w_held_ff;
	logic [7:0]          aw_addr_ff;
	logic [31:0]         w_data_ff;
	logic [3:0]          w_strb_ff;
	logic [23:0]         param_ff;
	logic [7:0]          enc_mode_ff;
	logic [7:0]          auth_en_ff;
	logic [23:0]         category_ff;
	logic [7:0]          rsp_status_ff;
	logic [23:0]         rsp_value_ff;
	logic [lccc_pkg::EVT_W-1:0] evt_stat_ff;
	logic [lccc_pkg::EVT_W-1:0] evt_en_ff;
	logic                irq_ff;

	logic                aw_take;
	logic                w_take;
	logic                ar_take;
	logic                nxt_aw_held;
	logic                nxt_w_held;
	logic                nxt_rvalid;
	logic                wr_fire;
	logic                wr_hit;
	logic                rd_hit;
	logic                wr_cmd;
	logic                wr_param;
	logic                wr_auth;
	logic                wr_clr;
	logic                wr_en;
	logic [31:0]         rd_word;
	logic [15:0]         cmd_code;
	logic [7:0]          new_mode;
	logic                mode_reserved;
	logic [7:0]          cmd_status;
	logic [23:0]         cmd_value;
	logic                cmd_set_mode;
	logic                cmd_set_cat;
	logic [lccc_pkg::EVT_W-1:0] evt_set;
	logic [lccc_pkg::EVT_W-1:0] evt_clr;
	logic [lccc_pkg::EVT_W-1:0] nxt_evt_stat;
	logic [31:0]         param_merged;
	logic [31:0]         en_merged;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// byte-lane merge of a write into an existing word
	function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// true when an address names a mapped register
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a <= lccc_pkg::REG_CONN) && (a[1:0] == 2'b00);
	endfunction

	// ----------------------------------------------------------------
	// write channels: address and data are caught in either order
	// ----------------------------------------------------------------
	assign aw_take     = s_axi_awvalid & awready_ff;
	assign w_take      = s_axi_wvalid & wready_ff;
	assign wr_fire     = (wr_state_ff == lccc_pkg::W_EXEC);
	assign nxt_aw_held = (aw_held_ff | aw_take) & ~wr_fire;
	assign nxt_w_held  = (w_held_ff | w_take) & ~wr_fire;

	// write sequencing: collect both halves, act once, then answer
	always_comb begin
		nxt_wr_state = wr_state_ff;
		case (wr_state_ff)
			lccc_pkg::W_WAIT: begin
				if (nxt_aw_held && nxt_w_held) begin
					nxt_wr_state = lccc_pkg::W_EXEC;
				end
			end
			lccc_pkg::W_EXEC: nxt_wr_state = lccc_pkg::W_RESP;
			lccc_pkg::W_RESP: begin
				if (s_axi_bready) begin
					nxt_wr_state = lccc_pkg::W_WAIT;
				end
			end
			default: nxt_wr_state = lccc_pkg::W_WAIT;
		endcase
	end

	// write channel handshake registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_state_ff <= lccc_pkg::W_WAIT;
			aw_held_ff  <= 1'b0;
			w_held_ff   <= 1'b0;
			awready_ff  <= 1'b0;
			wready_ff   <= 1'b0;
			bvalid_ff   <= 1'b0;
			bresp_ff    <= lccc_pkg::RESP_OKAY;
		end else begin
			wr_state_ff <= nxt_wr_state;
			aw_held_ff  <= nxt_aw_held;
			w_held_ff   <= nxt_w_held;
			awready_ff  <= ~nxt_aw_held & (nxt_wr_state == lccc_pkg::W_WAIT);
			wready_ff   <= ~nxt_w_held & (nxt_wr_state == lccc_pkg::W_WAIT);
			bvalid_ff   <= (nxt_wr_state == lccc_pkg::W_RESP);
			if (wr_fire) begin
				bresp_ff <= wr_hit ? lccc_pkg::RESP_OKAY : lccc_pkg::RESP_SLVERR;
			end
		end
	end

	// payload capture, no reset needed past the held flags
	always_ff @(posedge clk) begin
		if (aw_take) begin
			aw_addr_ff <= s_axi_awaddr;
		end
		if (w_take) begin
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	assign wr_hit       = addr_mapped(aw_addr_ff);
	assign wr_cmd       = wr_fire && (aw_addr_ff == lccc_pkg::REG_CMD);
	assign wr_param     = wr_fire && (aw_addr_ff == lccc_pkg::REG_PARAM);
	assign wr_auth      = wr_fire && (aw_addr_ff == lccc_pkg::REG_AUTH) && w_strb_ff[0];
	assign wr_clr       = wr_fire && (aw_addr_ff == lccc_pkg::REG_EVT_CLR);
	assign wr_en        = wr_fire && (aw_addr_ff == lccc_pkg::REG_EVT_EN);
	assign param_merged = lane_merge({8'h00, param_ff}, w_data_ff, w_strb_ff);
	assign en_merged    = lane_merge({30'h0000_0000, evt_en_ff}, w_data_ff, w_strb_ff);

	// ----------------------------------------------------------------
	// command execution: the argument sits in the parameter register before the code lands
	// ----------------------------------------------------------------
	assign cmd_code      = w_data_ff[15:0];
	assign new_mode      = param_ff[7:0];
	assign mode_reserved = (new_mode > lccc_pkg::ENC_BOTH); // RQ3

	// outcome of one command; local capability spans every defined mode, so only reserved mode codes and unknown command codes fail
	always_comb begin
		cmd_status   = lccc_pkg::ST_OK; // RQ10
		cmd_value    = 24'h00_0000;
		cmd_set_mode = 1'b0;
		cmd_set_cat  = 1'b0;
		case (cmd_code)
			lccc_pkg::OCF_RD_ENC: cmd_value = {16'h0000, enc_mode_ff}; // RQ1
			lccc_pkg::OCF_WR_ENC: begin
				if (mode_reserved) begin
					cmd_status = lccc_pkg::ST_BAD_PARAM; // RQ16
				end else begin
					cmd_set_mode = 1'b1; // RQ2
				end
			end
			lccc_pkg::OCF_RD_CAT: cmd_value = category_ff; // RQ12
			lccc_pkg::OCF_WR_CAT: cmd_set_cat = 1'b1; // RQ13
			default: cmd_status = lccc_pkg::ST_UNK_CMD; // RQ10
		endcase
	end

	// stored settings and the answer of the last command
	always_ff @(posedge clk) begin
		if (!nrst) begin
			param_ff      <= 24'h00_0000;
			enc_mode_ff   <= lccc_pkg::ENC_RST; // RQ3
			auth_en_ff    <= lccc_pkg::AUTH_RST; // RQ15
			category_ff   <= lccc_pkg::CAT_RST;
			rsp_status_ff <= lccc_pkg::ST_OK;
			rsp_value_ff  <= 24'h00_0000;
		end else begin
			if (wr_param) begin
				param_ff <= param_merged[23:0];
			end
			if (wr_auth && (w_data_ff[7:0] <= lccc_pkg::AUTH_ON)) begin
				auth_en_ff <= w_data_ff[7:0]; // RQ15
			end
			if (wr_cmd) begin
				rsp_status_ff <= cmd_status;
				rsp_value_ff  <= cmd_value;
				if (cmd_set_mode) begin
					enc_mode_ff <= new_mode; // RQ2
				end
				if (cmd_set_cat) begin
					category_ff <= param_ff; // RQ13
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	// every command completes, failed ones included
	assign evt_set[lccc_pkg::EVT_CMD_DONE] = wr_cmd; // RQ11
	assign evt_set[lccc_pkg::EVT_CONN]     = conn_done;
	assign evt_clr      = wr_clr ? w_data_ff[lccc_pkg::EVT_W-1:0] : '0;
	// set beats clear so an event landing on a clear is kept
	assign nxt_evt_stat = (evt_stat_ff & ~evt_clr) | evt_set;

	// sticky status, enable mask and the level interrupt
	always_ff @(posedge clk) begin
		if (!nrst) begin
			evt_stat_ff <= '0;
			evt_en_ff   <= '0;
			irq_ff      <= 1'b0;
		end else begin
			evt_stat_ff <= nxt_evt_stat;
			if (wr_en) begin
				evt_en_ff <= en_merged[lccc_pkg::EVT_W-1:0];
			end
			irq_ff <= |(nxt_evt_stat & (wr_en ? en_merged[lccc_pkg::EVT_W-1:0] : evt_en_ff)); // RQ11
		end
	end

	// ----------------------------------------------------------------
	// read channel: one outstanding read, answered the cycle after
	// ----------------------------------------------------------------
	assign ar_take    = s_axi_arvalid & arready_ff;
	assign nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
	assign rd_hit     = addr_mapped(s_axi_araddr);

	// read decode; the clear register and command register read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			lccc_pkg::REG_PARAM:    rd_word = {8'h00, param_ff};
			lccc_pkg::REG_STATUS:   rd_word = {24'h00_0000, rsp_status_ff};
			lccc_pkg::REG_VALUE:    rd_word = {8'h00, rsp_value_ff};
			lccc_pkg::REG_AUTH:     rd_word = {24'h00_0000, auth_en_ff};
			lccc_pkg::REG_EVT_STAT: rd_word = {30'h0000_0000, evt_stat_ff};
			lccc_pkg::REG_EVT_EN:   rd_word = {30'h0000_0000, evt_en_ff};
			lccc_pkg::REG_CONN:     rd_word = {22'h00_0000, conn_res.temp_key, conn_res.encrypt, conn_res.mode};
			default:                rd_word = 32'h0000_0000;
		endcase
	end

	// read handshake and data registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= lccc_pkg::RESP_OKAY;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_take) begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_hit ? lccc_pkg::RESP_OKAY : lccc_pkg::RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// connection setup
	// ----------------------------------------------------------------
	lccc_conn_setup u_conn (
		.clk        (clk),
		.nrst       (nrst),
		.setup_req  (conn_setup_req),
		.remote_cap (conn_remote_cap),
		.auth_en    (auth_en_ff),
		.enc_mode   (enc_mode_ff),
		.result_ff  (conn_res),
		.done_ff    (conn_done)
	);

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign s_axi_awready        = awready_ff;
	assign s_axi_wready         = wready_ff;
	assign s_axi_bvalid         = bvalid_ff;
	assign s_axi_bresp          = bresp_ff;
	assign s_axi_arready        = arready_ff;
	assign s_axi_rvalid         = rvalid_ff;
	assign s_axi_rdata          = rdata_ff;
	assign s_axi_rresp          = rresp_ff;
	assign conn_encrypt         = conn_res.encrypt;
	assign conn_mode            = conn_res.mode;
	assign conn_temp_key        = conn_res.temp_key;
	assign device_category_code = category_ff; // RQ14
	assign irq                  = irq_ff;

endmodule

// [lccc_checker.sv]
// assertion checker for the cipher and category configuration block
`timescale 1ns/1ps
module lccc_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// write handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// connection setup and category output
	input wire logic        conn_setup_req,
	input wire logic [1:0]  conn_remote_cap,
	input wire logic        conn_done,
	input wire logic        conn_encrypt,
	input wire logic [7:0]  conn_mode,
	input wire logic        conn_temp_key,
	input wire logic [23:0] device_category_code
);
	// ----------------------------------------------------------------
	// properties, one clock domain
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// both halves taken, one exec cycle, then the answer
	sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_bans; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
	property p_wans; s_wtake |=> s_bans; endproperty
	a_wans: assert property (p_wans) else $error("write answer off time");
	property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdrop: assert property (p_bdrop) else $error("write answer held too long");
	property p_done; conn_setup_req |=> conn_done; endproperty
	a_done: assert property (p_done) else $error("setup not answered");
	property p_rng; conn_done |-> conn_mode <= 8'h02; endproperty
	a_rng: assert property (p_rng) else $error("resolved mode out of range");
	property p_enc; conn_done |-> conn_encrypt == (conn_mode != 8'h00); endproperty
	a_enc: assert property (p_enc) else $error("encrypt flag disagrees with mode");
	property p_temp; conn_done |-> conn_temp_key == (conn_mode == 8'h02); endproperty
	a_temp: assert property (p_temp) else $error("temporary key flag wrong");
	// a weak remote caps the resolved mode
	sequence s_weak; conn_setup_req && conn_remote_cap < 2'h2; endsequence
	property p_trim; s_weak |=> conn_mode <= {6'h00, $past(conn_remote_cap)}; endproperty
	a_trim: assert property (p_trim) else $error("mode above remote capability");
	property p_hold; !conn_setup_req |=> $stable(conn_mode) && $stable(conn_encrypt); endproperty
	a_hold: assert property (p_hold) else $error("connection outcome moved");
	// the category output moves only as a write completes
	property p_cat; $changed(device_category_code) && $past(nrst) |-> s_axi_bvalid && !$past(s_axi_bvalid); endproperty
	a_cat: assert property (p_cat) else $error("category changed without a write");
endmodule

bind lccc_top lccc_checker u_chk (.*);

// [lccc_host.sv]
// host model issuing register accesses and commands over the register bus
`timescale 1ns/1ps
module lccc_host (
	// clock
	input wire logic         clk,
	// write channels
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input wire logic         s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input wire logic         s_axi_wready,
	input wire logic [1:0]   s_axi_bresp,
	input wire logic         s_axi_bvalid,
	output logic             s_axi_bready,
	// read channels
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic [31:0]  s_axi_rdata,
	input wire logic [1:0]   s_axi_rresp,
	input wire logic         s_axi_rvalid,
	output logic             s_axi_rready
);
	// ----------------------------------------------------------------
	// bus master
	// ----------------------------------------------------------------
	// idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end

	// released lines show the inverse so stale data cannot pass
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic td;
		ta = 1'b0;
		td = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && td)) begin
			@(posedge clk);
			if (!ta && s_axi_awready) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (!td && s_axi_wready) begin
				td = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// argument first; mode arguments are passed on unchecked, reserved ones included
	task automatic cmd(input logic [15:0] code, input logic [23:0] arg, output logic [7:0] st,
		output logic [23:0] val);
		logic [31:0] d;
		logic [1:0]  r;
		wr(lccc_pkg::REG_PARAM, {8'h00, arg}, r);
		wr(lccc_pkg::REG_CMD, {16'h0000, code}, r);
		rd(lccc_pkg::REG_STATUS, d, r);
		st = d[7:0];
		rd(lccc_pkg::REG_VALUE, d, r);
		val = d[23:0];
	endtask
endmodule

// [lccc_top_tb.sv]
// self-checking testbench for the cipher and category configuration block
`timescale 1ns/1ps
module lccc_top_tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        conn_setup_req = 1'b0;
	logic [1:0]  conn_remote_cap = 2'h0;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic        conn_done, conn_encrypt, conn_temp_key, irq;
	logic [7:0]  conn_mode;
	logic [23:0] device_category_code;
	int          err_total = 0;
	int          check_count = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	lccc_top uut (.*);
	lccc_host host (.*);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one setup pulse; capability scrambled once no longer sampled
	task automatic setup(input logic [1:0] cap);
		@(posedge clk);
		conn_setup_req <= 1'b1;
		conn_remote_cap <= cap;
		@(posedge clk);
		conn_setup_req <= 1'b0;
		conn_remote_cap <= ~cap;
		#1;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	logic [7:0]  st;
	logic [23:0] v;
	logic [31:0] d;
	logic [1:0]  r;

	task automatic t_reset;
		chk("category at reset", 32'h0, 32'(device_category_code));
		host.cmd(lccc_pkg::OCF_RD_ENC, 24'h0, st, v);
		chk("read mode status", 32'(lccc_pkg::ST_OK), 32'(st));
		chk("default mode", 32'h0, 32'(v));
		host.wr(8'h40, 32'h1234_5678, r);
		chk("unmapped write resp", 32'(lccc_pkg::RESP_SLVERR), 32'(r));
		host.rd(8'h40, d, r);
		chk("unmapped read resp", 32'(lccc_pkg::RESP_SLVERR), 32'(r));
		chk("unmapped read data", 32'h0, d);
		$display("test reset finished");
	endtask

	// mode codes 0 to 3; the reserved one last must leave mode 2
	task automatic t_enc;
		for (int m = 0; m < 4; m++) begin
			host.cmd(lccc_pkg::OCF_WR_ENC, 24'(m), st, v);
			chk("write mode status", m < 3 ? 32'h0 : 32'(lccc_pkg::ST_BAD_PARAM), 32'(st));
			host.cmd(lccc_pkg::OCF_RD_ENC, 24'h0, st, v);
			chk("read mode value", m < 3 ? 32'(m) : 32'h2, 32'(v));
		end
		host.cmd(16'h0025, 24'h0, st, v);
		chk("unknown code status", 32'(lccc_pkg::ST_UNK_CMD), 32'(st));
		$display("test mode finished");
	endtask

	task automatic t_cat;
		host.cmd(lccc_pkg::OCF_WR_CAT, 24'h5A_C31E, st, v);
		chk("write category status", 32'h0, 32'(st));
		chk("category output", 32'h005A_C31E, 32'(device_category_code));
		host.cmd(lccc_pkg::OCF_RD_CAT, 24'h0, st, v);
		chk("read category value", 32'h005A_C31E, 32'(v));
		$display("test category finished");
	endtask

	// every auth, mode and remote capability mix
	task automatic t_conn;
		logic [1:0] t;
		logic       e;
		for (int a = 0; a < 2; a++) begin
			host.wr(lccc_pkg::REG_AUTH, 32'(a), r);
			for (int m = 0; m < 3; m++) begin
				host.cmd(lccc_pkg::OCF_WR_ENC, 24'(m), st, v);
				for (int c = 0; c < 4; c++) begin
					t = (c < m) ? 2'(c) : 2'(m);
					e = (a == 1) && (t != 2'h0);
					setup(2'(c));
					chk("conn_done", 32'h1, 32'(conn_done));
					chk("conn_encrypt", 32'(e), 32'(conn_encrypt));
					chk("conn_mode", e ? 32'(t) : 32'h0, 32'(conn_mode));
					chk("conn_temp_key", 32'(e && t == 2'h2), 32'(conn_temp_key));
				end
			end
		end
		host.cmd(lccc_pkg::OCF_WR_ENC, 24'h0, st, v);
		chk("mode kept", 32'h2, 32'(conn_mode));
		chk("encrypt kept", 32'h1, 32'(conn_encrypt));
		host.rd(lccc_pkg::REG_CONN, d, r);
		chk("conn register", 32'h0000_0302, d);
		host.wr(lccc_pkg::REG_AUTH, 32'h2, r);
		host.rd(lccc_pkg::REG_AUTH, d, r);
		chk("reserved auth ignored", 32'h1, d);
		$display("test connection finished");
	endtask

	// masked events still record; the enable gates only the line
	task automatic t_irq;
		host.wr(lccc_pkg::REG_EVT_EN, 32'h0, r);
		host.wr(lccc_pkg::REG_EVT_CLR, 32'h3, r);
		host.cmd(lccc_pkg::OCF_RD_CAT, 24'h0, st, v);
		host.rd(lccc_pkg::REG_EVT_STAT, d, r);
		chk("event status", 32'h1, d);
		chk("masked irq", 32'h0, 32'(irq));
		host.wr(lccc_pkg::REG_EVT_EN, 32'h1, r);
		repeat (2) @(posedge clk);
		chk("irq raised", 32'h1, 32'(irq));
		host.wr(lccc_pkg::REG_EVT_CLR, 32'h1, r);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, 32'(irq));
		$display("test interrupt finished");
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_enc();
		t_cat();
		t_conn();
		t_irq();
		close_out();
	end

	// watchdog: tests need under a thousand cycles
	initial begin
		#(25 * 5000);
		err_total++;
		close_out();
	end
endmodule
